// ===== bench/eeprom_slave_sva.sv
// concurrent checks on the serial eeprom slave ports
module eeprom_slave_sva #(
    parameter WRITE_CYCLES = 200
) (
    input logic sys_clk_i,
    input logic arst_n_i,
    input logic scl_i,
    input logic sda_i,
    input logic sda_o,
    input logic sda_oe_o,
    input logic write_protect_i,
    input logic busy_o,
    input logic soft_protect_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [31:0] busy_cnt_ff;
    // cycles spent busy so far; a counter since the cycle is far too long to unroll
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_cnt_ff <= 32'h0;
        end else begin
            busy_cnt_ff <= busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
        end
    end
    // --------------------------------------------------------------
    // write cycle, flag and data line
    // --------------------------------------------------------------
    // exact cycle length
    chk_busy_length: assert property ($fell(busy_o) |-> busy_cnt_ff == 32'(WRITE_CYCLES))
        else $error("write cycle length wrong");
    chk_busy_after_stop: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("write cycle began without a stop");
    chk_no_ack_busy: assert property (busy_o |-> !sda_oe_o)
        else $error("line driven during write cycle");
    chk_flag_sticky: assert property (soft_protect_o |=> soft_protect_o)
        else $error("protect flag cleared");
    chk_flag_pin: assert property ($rose(soft_protect_o) |-> !write_protect_i)
        else $error("flag set while pin high");
    chk_flag_cycle: assert property ($rose(soft_protect_o) |-> ##[0:2] busy_o)
        else $error("flag set outside a write cycle");
    chk_open_drain: assert property (sda_oe_o |-> !sda_o)
        else $error("data driven high");
    chk_oe_stable: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data moved while clock high");
endmodule // eeprom_slave_sva

bind eeprom_slave eeprom_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .write_protect_i(write_protect_i),
    .busy_o(busy_o), .soft_protect_o(soft_protect_o));

// ===== bench/i2c_eeprom_access_protect_bench.sv
// self-checking bench for the serial eeprom slave
module i2c_eeprom_access_protect_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wp = 1'b0;
    logic sp = 1'b0;
    logic [2:0] cs = 3'h5;
    logic [31:0] rnd = 32'h37D3;
    logic [7:0] mem [256];
    logic [7:0] ptr;
    wire scl, sda_m, sda_oe, sda_do, busy, sprot;
    wire sda = sda_m & ~sda_oe;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    eeprom_slave #(.WRITE_CYCLES(200)) dut_u (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_do), .sda_oe_o(sda_oe), .chip_select_bit0(cs[0]),
        .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]),
        .write_protect_i(wp), .busy_o(busy), .soft_protect_o(sprot));
    i2c_master_model m_u (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    always #12.5 sys_clk_i = ~sys_clk_i;
    // --------------------------------------------------------------
    // expectation helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] ctl(input logic [3:0] code, input logic rd);
        return {code, cs, rd};
    endfunction
    // pin covers all, flag the lower half
    function automatic logic may_write(input logic [7:0] a);
        return !wp && !(sp && a <= 8'h7F);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // wait out the cycle by polling; first try must be refused
    task automatic poll();
        logic ak;
        ak = 1'b0;
        for (int i = 0; i < 20 && ak !== 1'b1; i++) begin
            m_u.start();
            m_u.tx(ctl(4'hA, 1'b0), ak);
            m_u.stop();
            if (i == 0) chk(8'(ak), 8'h0);
        end
        chk(8'(ak), 8'h1);
        chk(8'(busy), 8'h0);
    endtask
    task automatic nak(input logic [7:0] c);
        logic ak;
        m_u.start();
        m_u.tx(c, ak);
        m_u.stop();
        chk(8'(ak), 8'h0);
    endtask
    // write n random bytes from a, then poll
    task automatic wr(input logic [3:0] code, input logic [7:0] a, input int n);
        logic ak;
        logic [7:0] d;
        m_u.start();
        m_u.tx(ctl(code, 1'b0), ak);
        chk(8'(ak), 8'h1);
        m_u.tx(a, ak);
        chk(8'(ak), 8'h1);
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0];
            m_u.tx(d, ak);
            chk(8'(ak), 8'h1);
            // low nibble steps and wraps, later bytes overwrite
            if (code == 4'hA && may_write(a)) mem[a] = d;
            a[3:0] = a[3:0] + 4'h1;
        end
        m_u.stop();
        // write cycle runs from the stop
        chk(8'(busy), 8'h1);
        // pointer ends one past the last byte written
        ptr = a;
        if (code == 4'h6 && !wp) sp = 1'b1;
        poll();
    endtask
    // optional pointer load by an aborted write, then n sequential reads
    task automatic rd(input logic set, input logic [7:0] a, input int n);
        logic ak;
        logic [7:0] d;
        m_u.start();
        if (set) begin
            m_u.tx(ctl(4'hA, 1'b0), ak);
            m_u.tx(a, ak);
            chk(8'(ak), 8'h1);
            m_u.start();
            ptr = a;
        end
        m_u.tx(ctl(4'hA, 1'b1), ak);
        chk(8'(ak), 8'h1);
        // reads stay inside this one device's array
        for (int i = 0; i < n; i++) begin
            m_u.rx(i < n - 1, d);
            chk(d, mem[ptr]);
            ptr = ptr + 8'h1;
        end
        m_u.stop();
        chk(8'(sda_oe), 8'h0);
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        nak({4'hA, ~cs, 1'b0});
        nak(ctl(4'h5, 1'b0));
        nak(ctl(4'h6, 1'b1));
        wr(4'hA, 8'hF4, 18);
        rd(1'b0, 8'h00, 1);
        wr(4'hA, 8'h00, 1);
        rd(1'b1, 8'hF0, 16);
        rd(1'b1, 8'hFF, 1);
        rd(1'b0, 8'h00, 1);
        @(posedge sys_clk_i) wp <= 1'b1;
        wr(4'h6, 8'h00, 1);
        chk(8'(sprot), 8'h0);
        wr(4'hA, 8'hF0, 3);
        @(posedge sys_clk_i) wp <= 1'b0;
        wr(4'h6, 8'h00, 1);
        chk(8'(sprot), 8'h1);
        nak(ctl(4'h6, 1'b0));
        wr(4'hA, 8'h00, 1);
        wr(4'hA, 8'h80, 1);
        rd(1'b1, 8'hF0, 16);
        rd(1'b1, 8'h00, 1);
        rd(1'b1, 8'h80, 1);
        conclude();
    end
    // hang guard, several times the expected run length
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            conclude();
        end
    end
endmodule // i2c_eeprom_access_protect_bench

// ===== bench/i2c_master_model.sv
// two-wire bus master model: clock idles high, line released reads as pull-up
module i2c_master_model (
    input logic sys_clk_i,
    input logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // one 200 ns bit; data moves in clock low, sampled mid high
    task automatic bit_x(input logic b, output logic r);
        #25 sda_o = b;
        #75 scl_o = 1'b1;
        #50 r = sda_i;
        #50 scl_o = 1'b0;
    endtask
    // start, also used as repeated start
    task automatic start();
        @(negedge sys_clk_i);
        #25 sda_o = 1'b1;
        #75 scl_o = 1'b1;
        #100 sda_o = 1'b0;
        #100 scl_o = 1'b0;
    endtask
    task automatic stop();
        #25 sda_o = 1'b0;
        #75 scl_o = 1'b1;
        #100 sda_o = 1'b1;
        #100;
    endtask
    // byte out, msb first, ack returned as 1
    task automatic tx(input logic [7:0] d, output logic ak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ak = ~r;
    endtask
    // byte in, then ack to continue or nack to end
    task automatic rx(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~more, r);
    endtask
endmodule // i2c_master_model

// ===== logic/bit_sync.v
// two-flop synchroniser for one asynchronous level
module bit_sync (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire async_i,
    output wire sync_o
);
    reg meta_ff;
    reg sync_ff;
    // first stage feeds only the second stage
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule // bit_sync

// ===== logic/eeprom_defines.vh
// timing counts, control codes and sizes for the serial eeprom slave
`ifndef EEPROM_DEFINES_VH
`define EEPROM_DEFINES_VH
`define CODE_ARRAY 4'hA
`define CODE_PROTECT 4'h6
`define ARRAY_DEPTH 256
`define PAGE_DEPTH 16
`define HALF_TOP 8'h7F
`define CLK_HZ 40000000
`define WRITE_CYCLE_MS 10
`define WRITE_CYCLE_CYC ((`CLK_HZ / 1000) * `WRITE_CYCLE_MS)
`endif

// ===== logic/eeprom_slave.v
// two-wire serial eeprom slave with page buffer and write protection
`include "eeprom_defines.vh"
// How it works
// - byte after write control loads pointer
// - stop starts write cycle, no acks
// - protected writes acked but discarded
// - up to sixteen bytes buffered until stop
// - write increments only low pointer nibble
// - over sixteen bytes wrap and overwrite
// - busy device ignores polling control byte
// - soft protect covers 00h to 7Fh
// - code 0110 write sets protect flag
// - set flag stops acking 0110 code
// - protect flag never cleared by command
// - protect pin blocks whole array
// - protect pin blocks setting flag
// - pin low: soft flag decides alone
// - read sends byte at pointer
// - master nack ends read, line released
// - repeated start keeps new pointer
// - pointer ends one past last read
// - master ack fetches next byte
// - chip select bits must match pins
// - 1010 array, 0110 protect, 0110 read nacked
// - last control bit picks direction
module eeprom_slave #(
    parameter WRITE_CYCLES = `WRITE_CYCLE_CYC,
    parameter PROTECT_INIT = 1'b0
) (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    input wire chip_select_bit0,
    input wire chip_select_bit1,
    input wire chip_select_bit2,
    input wire write_protect_i,
    output reg busy_o,
    output reg soft_protect_o
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam ST_IDLE = 6'b000001;
    localparam ST_CTRL = 6'b000010;
    localparam ST_ADDR = 6'b000100;
    localparam ST_WDAT = 6'b001000;
    localparam ST_RDAT = 6'b010000;
    localparam ST_RACK = 6'b100000;

    // ------------------------------------------------------------
    // input synchronisers and edge detect
    // ------------------------------------------------------------
    wire scl_s;
    wire sda_s;
    wire wp_s;
    bit_sync u_scl (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .async_i(scl_i), .sync_o(scl_s));
    bit_sync u_sda (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .async_i(sda_i), .sync_o(sda_s));
    bit_sync u_wp (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .async_i(write_protect_i),
        .sync_o(wp_s));
    // protect pin idles low but its synchroniser resets high; harmless, since
    // nothing that reads the pin commits or sets the flag within two clocks of reset
    // chip select straps are pins too, so they take the same two flops
    wire [2:0] cs_raw = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
    wire [2:0] cs_pins;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_cs_sync
            bit_sync u_cs (
                .sys_clk_i(sys_clk_i),
                .arst_n_i(arst_n_i),
                .async_i(cs_raw[g]),
                .sync_o(cs_pins[g])
            );
        end
    endgenerate
    reg scl_d_ff;
    reg sda_d_ff;
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    // start and stop only while clock stays high
    wire start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // the array has no reset: a real part powers up holding its old contents
    reg [7:0] mem [0:`ARRAY_DEPTH-1];
    reg [7:0] page_ff [0:`PAGE_DEPTH-1];
    reg [`PAGE_DEPTH-1:0] page_vld_ff;
    reg [7:0] ptr_ff;
    reg [3:0] page_base_ff;
    reg [5:0] state_ff;
    reg [7:0] shift_ff;
    reg [3:0] bitcnt_ff;
    reg ack_phase_ff;
    reg is_prot_ff;
    reg got_data_ff;
    reg [31:0] wcnt_ff;
    reg commit_ff;
    reg [4:0] commit_idx_ff;

    wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
    // decode the finished byte in shift_ff; rx_byte is already one bit further on
    // chip select match
    wire cs_ok = (shift_ff[3:1] == cs_pins);
    // code decode; used flag nacks 0110; direction bit
    wire ctl_arr = (shift_ff[7:4] == `CODE_ARRAY);
    wire ctl_prot = (shift_ff[7:4] == `CODE_PROTECT) & ~shift_ff[0] & ~soft_protect_o;
    wire ctl_ack = cs_ok & (ctl_arr | ctl_prot) & ~busy_o;

    // ------------------------------------------------------------
    // write cycle timer and commit of page buffer
    // ------------------------------------------------------------
    // pin blocks all; flag blocks lower half; else flag only
    // commit walks the sixteen slots in sixteen clocks, well inside the cycle
    wire [7:0] commit_addr = {page_base_ff, commit_idx_ff[3:0]};
    wire blocked = wp_s | (soft_protect_o & (commit_addr <= `HALF_TOP));
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_o <= 1'b0;
            wcnt_ff <= 32'h00000000;
            commit_idx_ff <= 5'h00;
            commit_ff <= 1'b0;
            soft_protect_o <= 1'b0;
        end else begin
            // strap image of the nonvolatile flag; never cleared afterwards
            if (PROTECT_INIT)
                soft_protect_o <= 1'b1;
            // a stop after a bare address or a refused byte starts no cycle
            if (stop_ev && got_data_ff && !busy_o) begin
                // stop starts write cycle; runs even if protected
                busy_o <= 1'b1;
                wcnt_ff <= WRITE_CYCLES;
                commit_ff <= ~is_prot_ff;
                commit_idx_ff <= 5'h00;
                // flag set; refused while pin high; sticky
                if (is_prot_ff && !wp_s)
                    soft_protect_o <= 1'b1;
            end else if (busy_o) begin
                // commit buffered bytes only after stop
                if (commit_ff && !commit_idx_ff[4]) begin
                    if (page_vld_ff[commit_idx_ff[3:0]] && !blocked)
                        mem[commit_addr] <= page_ff[commit_idx_ff[3:0]];
                    commit_idx_ff <= commit_idx_ff + 5'h01;
                end
                if (wcnt_ff <= 32'h00000001)
                    busy_o <= 1'b0;
                else
                    wcnt_ff <= wcnt_ff - 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------
    // bus protocol engine
    // ------------------------------------------------------------
    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            bitcnt_ff <= 4'h0;
            ack_phase_ff <= 1'b0;
            ptr_ff <= 8'h00;
            page_base_ff <= 4'h0;
            page_vld_ff <= {`PAGE_DEPTH{1'b0}};
            is_prot_ff <= 1'b0;
            got_data_ff <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_ev) begin
            // repeated start aborts write, pointer kept
            state_ff <= ST_CTRL;
            bitcnt_ff <= 4'h0;
            ack_phase_ff <= 1'b0;
            got_data_ff <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (stop_ev) begin
            state_ff <= ST_IDLE;
            sda_oe_o <= 1'b0;
            got_data_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                // eight rising edges make a byte; the ninth clock carries the acknowledge
                ST_CTRL, ST_ADDR, ST_WDAT: begin
                    if (scl_rise && !ack_phase_ff) begin
                        shift_ff <= rx_byte;
                        bitcnt_ff <= bitcnt_ff + 4'h1;
                        if (bitcnt_ff == 4'h7)
                            ack_phase_ff <= 1'b1;
                    end
                    if (scl_fall && ack_phase_ff && bitcnt_ff == 4'h8) begin
                        // byte complete: decide acknowledge
                        bitcnt_ff <= 4'h9;
                        if (state_ff == ST_CTRL) begin
                            if (ctl_ack) begin
                                sda_o <= 1'b0;
                                sda_oe_o <= 1'b1;
                                is_prot_ff <= ~ctl_arr;
                            end else begin
                                state_ff <= ST_IDLE;
                            end
                        end else if (state_ff == ST_ADDR) begin
                            ptr_ff <= shift_ff;
                            page_base_ff <= shift_ff[7:4];
                            page_vld_ff <= {`PAGE_DEPTH{1'b0}};
                            sda_o <= 1'b0;
                            sda_oe_o <= 1'b1;
                        end else begin
                            if (!is_prot_ff) begin
                                page_ff[ptr_ff[3:0]] <= shift_ff;
                                page_vld_ff[ptr_ff[3:0]] <= 1'b1;
                            end
                            ptr_ff <= {ptr_ff[7:4], ptr_ff[3:0] + 4'h1};
                            got_data_ff <= 1'b1;
                            sda_o <= 1'b0;
                            sda_oe_o <= 1'b1;
                        end
                    end else if (scl_fall && bitcnt_ff == 4'h9) begin
                        // end of ack clock: release and move on
                        sda_oe_o <= 1'b0;
                        bitcnt_ff <= 4'h0;
                        ack_phase_ff <= 1'b0;
                        if (state_ff == ST_CTRL && shift_ff[0]) begin
                            state_ff <= ST_RDAT;
                            shift_ff <= mem[ptr_ff];
                            sda_o <= 1'b0;
                            sda_oe_o <= ~mem[ptr_ff][7];
                            bitcnt_ff <= 4'h1;
                        end else if (state_ff == ST_CTRL) begin
                            state_ff <= ST_ADDR;
                        end else begin
                            state_ff <= ST_WDAT;
                        end
                    end
                end
                // data moves only after the clock fall is seen, so it never changes
                // while the clock is high and cannot fake a start or stop
                ST_RDAT: begin
                    if (scl_fall) begin
                        if (bitcnt_ff == 4'h8) begin
                            // release for master acknowledge
                            sda_oe_o <= 1'b0;
                            state_ff <= ST_RACK;
                            ptr_ff <= ptr_ff + 8'h01;
                        end else begin
                            // open drain: drive low only for zero bits
                            sda_o <= 1'b0;
                            sda_oe_o <= ~shift_ff[7 - bitcnt_ff[2:0]];
                            bitcnt_ff <= bitcnt_ff + 4'h1;
                        end
                    end
                end
                // next byte fetched on the rise so it is ready when the clock falls
                ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s)
                            state_ff <= ST_IDLE;
                        else
                            shift_ff <= mem[ptr_ff];
                    end else if (scl_fall) begin
                        state_ff <= ST_RDAT;
                        sda_o <= 1'b0;
                        sda_oe_o <= ~shift_ff[7];
                        bitcnt_ff <= 4'h1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // eeprom_slave
